// ### design/rcr_core.sv
/*
 * Clock/calendar register core: BCD time and date counters, one-hot
 * weekday, programmable four-pin port, user memory and read-only id.
 * Assumes a serial bus front end that turns each register access into a
 * one-cycle read or write strobe with a byte address and data.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// [RULE1] Seconds count 00..59 in BCD, wrap carries into minutes.
// [RULE2] Minutes count 00..59 in BCD, wrap carries into hours.
// [RULE3] Hours count 00..23, wrap advances weekday and date.
// [RULE4] Time and calendar registers are packed BCD, tens high nibble.
// [RULE5] Weekday is one-hot, shifts left daily, 40h wraps to 01h.
// [RULE6] Host writes only a single weekday bit.
// [RULE7] Date wraps after 31, 30 or 28 depending on month.
// [RULE8] Year divisible by four is leap; February reaches 29.
// [RULE9] Month counts 01..12 on date wrap, then carries into year.
// [RULE10] Year counts 00..99 on December wrap, then returns to 00.
// [RULE11] Host writes only valid time and calendar values.
// [RULE12] Fixed-zero bits ignore writes and read 0.
// [RULE13] Power-on reset sets the supply loss flag.
// [RULE14] Host writes test bits as 0 and masks them on read.
// [RULE15] Port register resets to cbh.
// [RULE16] Port bits 7..4 are directions, bits 3..0 data.
// [RULE17] Port data reads pin levels; directions read stored value.
// [RULE18] Port writes always load the latch; drive only when output.
// [RULE19] Direction change to output drives the latched value at once.
// [RULE20] Bytes 1A..1F are a read-only 48-bit identifier.
// [RULE21] User memory writes need the write enable bit; resets to 0.
// [RULE22] Host writes user memory one byte at a time, 1.8ms apart.
// [RULE23] All counters update on one tick with full carry chain.
module rcr_core
   import rcr_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES,
   parameter logic [47:0] UID_VALUE = UID_DEFAULT // Arbitrary value
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [3:0] port_pin_in,
   output logic [3:0] port_pin_out,
   output logic [3:0] port_pin_oe_out,
   output logic tick_out
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   localparam int TW = (TICK_LEN > 2) ? $clog2(TICK_LEN) : 2;

   if (TICK_LEN < 2) begin : g_bad_tick
      $error("TICK_LEN must be at least 2");
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      logic [7:0] r;
      r = v;
      if (v[3:0] >= 4'h9) begin
         r = {v[7:4] + 4'h1, 4'h0};
      end else begin
         r = {v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction

   function automatic logic leap_year(input logic [7:0] y);
      logic r;
      r = 1'b0;
      if (y[4] == 1'b0) begin
         r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end else begin
         r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
      return r;
   endfunction

   function automatic logic [7:0] last_date(input logic [7:0] m,
                                            input logic [7:0] y);
      logic [7:0] r;
      r = 8'h31;
      case (m)
         8'h02: r = leap_year(y) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
         default: r = 8'h31;
      endcase
      return r;
   endfunction

   function automatic logic wr_to(input logic [7:0] a);
      return reg_wr_in && (reg_addr_in == a);
   endfunction

   // ----------------------------------------------------------------
   // One second tick
   // ----------------------------------------------------------------
   logic [TW-1:0] tick_cnt_q;
   logic tick_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == TW'(TICK_LEN - 1)) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + TW'(1);
         tick_q <= 1'b0;
      end
   end

   assign tick_out = tick_q;

   // ----------------------------------------------------------------
   // Time and calendar counters
   // ----------------------------------------------------------------
   logic [7:0] sec_q, min_q, hour_q, wday_q, date_q, month_q, year_q;
   logic c_sec, c_min, c_hour, c_date, c_month;

   always_comb begin
      c_sec = tick_q && (sec_q == BCD_59); // RULE23
      c_min = c_sec && (min_q == BCD_59);
      c_hour = c_min && (hour_q == BCD_23);
      c_date = c_hour && (date_q == last_date(month_q, year_q));
      c_month = c_date && (month_q == BCD_12);
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         sec_q <= RST_TIME;
         min_q <= RST_TIME;
         hour_q <= RST_TIME;
      end else begin
         if (wr_to(ADDR_SEC)) begin
            sec_q <= reg_wdata_in & MASK_SEC; // RULE12
         end else if (tick_q) begin
            sec_q <= c_sec ? RST_TIME : bcd_inc(sec_q); // RULE1
         end
         if (wr_to(ADDR_MIN)) begin
            min_q <= reg_wdata_in & MASK_MIN;
         end else if (c_sec) begin
            min_q <= c_min ? RST_TIME : bcd_inc(min_q); // RULE2
         end
         if (wr_to(ADDR_HOUR)) begin
            hour_q <= reg_wdata_in & MASK_HOUR;
         end else if (c_min) begin
            hour_q <= c_hour ? RST_TIME : bcd_inc(hour_q); // RULE3
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         wday_q <= WDAY_FIRST;
         date_q <= RST_CAL;
         month_q <= RST_CAL;
         year_q <= RST_TIME;
      end else begin
         if (wr_to(ADDR_WDAY)) begin
            wday_q <= reg_wdata_in & MASK_WDAY;
         end else if (c_hour) begin
            wday_q <= (wday_q == WDAY_LAST) ? WDAY_FIRST
                      : {wday_q[6:0], 1'b0}; // RULE5
         end
         if (wr_to(ADDR_DATE)) begin
            date_q <= reg_wdata_in & MASK_DATE;
         end else if (c_hour) begin
            date_q <= c_date ? BCD_01 : bcd_inc(date_q); // RULE7 RULE8
         end
         if (wr_to(ADDR_MONTH)) begin
            month_q <= reg_wdata_in & MASK_MONTH;
         end else if (c_date) begin
            month_q <= c_month ? BCD_01 : bcd_inc(month_q); // RULE9
         end
         if (wr_to(ADDR_YEAR)) begin
            year_q <= reg_wdata_in; // RULE4
         end else if (c_month) begin
            year_q <= (year_q == BCD_99) ? RST_TIME
                      : bcd_inc(year_q); // RULE10
         end
      end
   end

   // ----------------------------------------------------------------
   // Match, countdown and function registers (storage only), flags and control
   // ----------------------------------------------------------------
   logic [7:0] mmin_q, mhour_q, mday_q, cdlo_q, cdhi_q, fsel_q, ctrl_q;
   logic supply_loss_flag_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         mmin_q <= '0;
         mhour_q <= '0;
         mday_q <= '0;
         cdlo_q <= '0;
         cdhi_q <= '0;
         fsel_q <= '0;
      end else begin
         if (wr_to(ADDR_MMIN)) mmin_q <= reg_wdata_in;
         if (wr_to(ADDR_MHOUR)) mhour_q <= reg_wdata_in;
         if (wr_to(ADDR_MDAY)) mday_q <= reg_wdata_in;
         if (wr_to(ADDR_CDLO)) cdlo_q <= reg_wdata_in;
         if (wr_to(ADDR_CDHI)) cdhi_q <= reg_wdata_in;
         if (wr_to(ADDR_FSEL)) fsel_q <= reg_wdata_in & MASK_FSEL;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         ctrl_q <= '0; // RULE21
         supply_loss_flag_q <= 1'b1; // RULE13
      end else begin
         if (wr_to(ADDR_CTRL)) begin
            ctrl_q <= reg_wdata_in & MASK_CTRL; // RULE12
         end
         if (wr_to(ADDR_FLAGS) && !reg_wdata_in[BIT_SUPPLY_LOSS]) begin
            supply_loss_flag_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Programmable port
   // ----------------------------------------------------------------
   logic [3:0] port_dir_q, port_lat_q;
   logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         port_dir_q <= RST_PORT[7:4]; // RULE15
         port_lat_q <= RST_PORT[3:0];
      end else if (wr_to(ADDR_PORT)) begin
         port_dir_q <= reg_wdata_in[7:4]; // RULE16
         port_lat_q <= reg_wdata_in[3:0]; // RULE18
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
         pin_lvl_q <= '0;
      end else begin
         pin_s1_q <= port_pin_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         for (int i = 0; i < 4; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) pin_lvl_q[i] <= pin_s3_q[i];
         end
      end
   end

   // Pins 0 and 1 are open drain: they only ever pull low
   always_comb begin
      port_pin_out = {port_lat_q[3:2], 2'b00};
      port_pin_oe_out = {port_dir_q[3:2],
                         port_dir_q[1:0] & ~port_lat_q[1:0]}; // RULE19
   end

   // ----------------------------------------------------------------
   // User memory and identifier
   // ----------------------------------------------------------------
   logic [7:0] nv_q [NV_BYTES];
   logic [3:0] nv_idx;
   logic [2:0] uid_idx;

   always_comb begin
      nv_idx = 4'(reg_addr_in - ADDR_NV_LO);
      uid_idx = 3'(reg_addr_in - ADDR_UID_LO);
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < NV_BYTES; i++) nv_q[i] <= '0;
      end else if (reg_wr_in && ctrl_q[BIT_NV_WREN] &&
                   reg_addr_in >= ADDR_NV_LO &&
                   reg_addr_in <= ADDR_NV_HI) begin
         nv_q[nv_idx] <= reg_wdata_in; // RULE21
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [7:0] rd_d, rdata_q;

   always_comb begin
      rd_d = 8'h00;
      case (reg_addr_in)
         ADDR_SEC: rd_d = sec_q;
         ADDR_MIN: rd_d = min_q;
         ADDR_HOUR: rd_d = hour_q;
         ADDR_WDAY: rd_d = wday_q;
         ADDR_DATE: rd_d = date_q;
         ADDR_MONTH: rd_d = month_q;
         ADDR_YEAR: rd_d = year_q;
         ADDR_PORT: rd_d = {port_dir_q, pin_lvl_q}; // RULE17
         ADDR_MMIN: rd_d = mmin_q;
         ADDR_MHOUR: rd_d = mhour_q;
         ADDR_MDAY: rd_d = mday_q;
         ADDR_CDLO: rd_d = cdlo_q;
         ADDR_CDHI: rd_d = cdhi_q;
         ADDR_FSEL: rd_d = fsel_q;
         ADDR_FLAGS: rd_d = {6'h00, supply_loss_flag_q, 1'b0}; // RULE12
         ADDR_CTRL: rd_d = ctrl_q;
         default: begin
            if (reg_addr_in >= ADDR_NV_LO && reg_addr_in <= ADDR_NV_HI) begin
               rd_d = nv_q[nv_idx];
            end else if (reg_addr_in >= ADDR_UID_LO &&
                         reg_addr_in <= ADDR_UID_HI) begin
               rd_d = UID_VALUE[8*uid_idx +: 8]; // RULE20
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         rdata_q <= '0;
      end else if (reg_rd_in) begin
         rdata_q <= rd_d;
      end
   end

   assign reg_rdata_out = rdata_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic time_wr;
   assign time_wr = reg_wr_in && (reg_addr_in <= ADDR_YEAR);

   property p_sec_wrap;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      tick_q && !time_wr && sec_q == BCD_59 |=>
         sec_q == RST_TIME && min_q != $past(min_q);
   endproperty
   a_sec_wrap: assert property (p_sec_wrap) // RULE1
      else $error("seconds did not wrap with carry");

   property p_min_wrap;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      c_min && !time_wr |=> min_q == RST_TIME && hour_q != $past(hour_q);
   endproperty
   a_min_wrap: assert property (p_min_wrap) // RULE2
      else $error("minutes did not wrap with carry");

   property p_hour_wrap;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      c_hour && !time_wr && wday_q == WDAY_LAST |=>
         hour_q == RST_TIME && wday_q == WDAY_FIRST;
   endproperty
   a_hour_wrap: assert property (p_hour_wrap) // RULE3
      else $error("hour rollover did not advance weekday");

   property p_wday_shift;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      c_hour && !time_wr && wday_q == 8'h08 |=> wday_q == 8'h10;
   endproperty
   a_wday_shift: assert property (p_wday_shift) // RULE5
      else $error("weekday did not shift left");

   property p_date_30;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      c_hour && !time_wr && month_q == 8'h04 && date_q == 8'h30 |=>
         date_q == BCD_01 && month_q == 8'h05;
   endproperty
   a_date_30: assert property (p_date_30) // RULE7
      else $error("April did not end after 30");

   property p_leap_feb;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      c_hour && !time_wr && month_q == 8'h02 && date_q == 8'h28 &&
         (year_q == 8'h00 || year_q == 8'h24) |=>
         date_q == 8'h29 && month_q == 8'h02;
   endproperty
   a_leap_feb: assert property (p_leap_feb) // RULE8
      else $error("leap February did not reach 29");

   property p_year_wrap;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      c_month && !time_wr && year_q == BCD_99 |=>
         year_q == RST_TIME && month_q == BCD_01 && date_q == BCD_01;
   endproperty
   a_year_wrap: assert property (p_year_wrap) // RULE10
      else $error("year did not wrap to 00");

   property p_flag_zero;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      reg_rd_in && reg_addr_in == ADDR_FLAGS |=> reg_rdata_out[0] == 1'b0
         && reg_rdata_out[7:2] == 6'h00;
   endproperty
   a_flag_zero: assert property (p_flag_zero) // RULE12
      else $error("fixed zero flag bits read nonzero");

   property p_port_drive;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      wr_to(ADDR_PORT) |=> port_pin_oe_out[3:2] == $past(reg_wdata_in[7:6])
         && port_pin_out[3:2] == $past(reg_wdata_in[3:2]);
   endproperty
   a_port_drive: assert property (p_port_drive) // RULE18
      else $error("port pins do not follow direction and latch");

   property p_nv_protect;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      wr_to(ADDR_NV_LO) && !ctrl_q[BIT_NV_WREN] |=> $stable(nv_q[0]);
   endproperty
   a_nv_protect: assert property (p_nv_protect) // RULE21
      else $error("protected user byte changed");

   property p_uid_ro;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      reg_rd_in && reg_addr_in == ADDR_UID_LO |=>
         reg_rdata_out == UID_VALUE[7:0];
   endproperty
   a_uid_ro: assert property (p_uid_ro) // RULE20
      else $error("identifier byte read wrong");

   property p_supply_flag;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(rstn_in) |-> supply_loss_flag_q ##1 (supply_loss_flag_q ||
         $past(reg_wr_in && reg_addr_in == ADDR_FLAGS));
   endproperty
   a_supply_flag: assert property (p_supply_flag) // RULE13
      else $error("supply loss flag not set after reset");

endmodule

`default_nettype wire

// ### design/rcr_pkg.sv
/*
 * Package for the clock/calendar register core: register offsets, write
 * masks, reset values and timing figures.
 * Assumes the single system clock runs at 250 MHz.
 */
package rcr_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 250_000_000;
   localparam int TICK_HZ = 1;
   localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
   localparam int SYNC_STAGES = 3;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SEC = 8'h00;
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_HOUR = 8'h02;
   localparam logic [7:0] ADDR_WDAY = 8'h03;
   localparam logic [7:0] ADDR_DATE = 8'h04;
   localparam logic [7:0] ADDR_MONTH = 8'h05;
   localparam logic [7:0] ADDR_YEAR = 8'h06;
   localparam logic [7:0] ADDR_PORT = 8'h07;
   localparam logic [7:0] ADDR_MMIN = 8'h08;
   localparam logic [7:0] ADDR_MHOUR = 8'h09;
   localparam logic [7:0] ADDR_MDAY = 8'h0a;
   localparam logic [7:0] ADDR_CDLO = 8'h0b;
   localparam logic [7:0] ADDR_CDHI = 8'h0c;
   localparam logic [7:0] ADDR_FSEL = 8'h0d;
   localparam logic [7:0] ADDR_FLAGS = 8'h0e;
   localparam logic [7:0] ADDR_CTRL = 8'h0f;
   localparam logic [7:0] ADDR_NV_LO = 8'h10;
   localparam logic [7:0] ADDR_NV_HI = 8'h19;
   localparam logic [7:0] ADDR_UID_LO = 8'h1a;
   localparam logic [7:0] ADDR_UID_HI = 8'h1f;
   localparam int NV_BYTES = 10;
   localparam int UID_BYTES = 6;

   // ----------------------------------------------------------------
   // Writable bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_SEC = 8'h7f;
   localparam logic [7:0] MASK_MIN = 8'h7f;
   localparam logic [7:0] MASK_HOUR = 8'h3f;
   localparam logic [7:0] MASK_WDAY = 8'h7f;
   localparam logic [7:0] MASK_DATE = 8'h3f;
   localparam logic [7:0] MASK_MONTH = 8'h1f;
   localparam logic [7:0] MASK_FSEL = 8'h7f;
   localparam logic [7:0] MASK_CTRL = 8'h7a;

   // ----------------------------------------------------------------
   // Field positions and values
   // ----------------------------------------------------------------
   localparam int BIT_SUPPLY_LOSS = 1;
   localparam int BIT_NV_WREN = 6;
   localparam logic [7:0] BCD_59 = 8'h59;
   localparam logic [7:0] BCD_23 = 8'h23;
   localparam logic [7:0] BCD_12 = 8'h12;
   localparam logic [7:0] BCD_99 = 8'h99;
   localparam logic [7:0] BCD_01 = 8'h01;
   localparam logic [7:0] WDAY_FIRST = 8'h01;
   localparam logic [7:0] WDAY_LAST = 8'h40;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_PORT = 8'hcb;
   localparam logic [7:0] RST_TIME = 8'h00;
   localparam logic [7:0] RST_CAL = 8'h01;
   localparam logic [47:0] UID_DEFAULT = 48'h5a_a5_3c_c3_0f_f0; // Arbitrary value

endpackage

// ### test/rcr_pin_model.sv
/*
 * Model of the board around the four port pins: core drive, an outside
 * source per pin, and a pull-up on every pin left undriven.
 * Assumes the drive enable and value come straight from the core.
 */
`timescale 1ns/1ns
`default_nettype none
module rcr_pin_model (
   input wire logic [3:0] oe_in,
   input wire logic [3:0] drv_in,
   input wire logic [3:0] ext_en_in,
   input wire logic [3:0] ext_val_in,
   output logic [3:0] level_out
);
   // Core drive first, then outside source, else pull-up
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         level_out[i] = oe_in[i] ? drv_in[i] :
            (ext_en_in[i] ? ext_val_in[i] : 1'b1);
      end
   end
endmodule
`default_nettype wire

// ### test/test_rtc_calendar_regmap_port.sv
/*
 * Self-checking bench for the clock/calendar register core.
 * Assumes a 250 MHz clock and a short tick period for simulation.
 */
`timescale 1ns/1ns
`default_nettype none
module test_rtc_calendar_regmap_port;
   import rcr_pkg::*;
   localparam int TL = 64;
   localparam logic [47:0] UID = 48'h61_72_63_74_65_6e; // Arbitrary value
   logic clk = 0, rstn = 0, wr = 0, rd = 0, tick;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
   logic [3:0] lvl, pout, poe, ext_en = 4'h0, ext_val = 4'h0, d, l;
   int err_count = 0, n_tests = 0;
   logic [7:0] t [7];
   logic [7:0] e [7];
   logic [7:0] fz [7] = '{8'h80, 8'h80, 8'hc0, 8'h00, 8'hc0, 8'he0, 8'h00};
   logic [55:0] cn [6] = '{56'h23_01_31_40_23_59_59,
      56'h23_04_30_08_23_59_59, 56'h23_02_28_02_23_59_59,
      56'h24_02_28_02_23_59_59, 56'h00_02_29_02_23_59_59,
      56'h99_12_31_20_23_59_59};

   rcr_core #(.TICK_LEN(TL), .UID_VALUE(UID)) u_rcr_core (
      .sys_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .port_pin_in(lvl), .port_pin_out(pout),
      .port_pin_oe_out(poe), .tick_out(tick));
   rcr_pin_model u_rcr_pin_model (.oe_in(poe), .drv_in(pout),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));

   initial begin
      forever #2 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Expectation helpers
   // ----------------------------------------------------------------
   function automatic int b2i(logic [7:0] b);
      return b[7:4] * 10 + b[3:0];
   endfunction
   function automatic logic [7:0] i2b(int i);
      return {4'(i / 10), 4'(i % 10)};
   endfunction
   function automatic int mdays(int m, int y);
      if (m == 2) return (y % 4 == 0) ? 29 : 28;
      if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
      return 31;
   endfunction
   function automatic void next_time();
      int s, m, h, dd, mo, y;
      s = b2i(t[0]) + 1;
      m = b2i(t[1]);
      h = b2i(t[2]);
      dd = b2i(t[4]);
      mo = b2i(t[5]);
      y = b2i(t[6]);
      e[3] = t[3];
      if (s == 60) begin
         s = 0;
         m++;
      end
      if (m == 60) begin
         m = 0;
         h++;
      end
      if (h == 24) begin
         h = 0;
         dd++;
         e[3] = (t[3] == 8'h40) ? 8'h01 : t[3] << 1;
      end
      if (dd > mdays(mo, y)) begin
         dd = 1;
         mo++;
      end
      if (mo == 13) begin
         mo = 1;
         y = (y + 1) % 100;
      end
      e[0] = i2b(s);
      e[1] = i2b(m);
      e[2] = i2b(h);
      e[4] = i2b(dd);
      e[5] = i2b(mo);
      e[6] = i2b(y);
   endfunction

   // ----------------------------------------------------------------
   // Register port tasks
   // ----------------------------------------------------------------
   task automatic chk(logic [7:0] got, logic [7:0] x);
      n_tests++;
      if (got !== x) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, x);
      end
   endtask
   task automatic wr_reg(logic [7:0] a, logic [7:0] dv);
      addr = a;
      wdata = dv;
      wr = 1;
      @(posedge clk);
      #1 wr = 0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd_chk(logic [7:0] a, logic [7:0] x, logic [7:0] m = 8'hff);
      addr = a;
      rd = 1;
      @(posedge clk);
      #1 rd = 0;
      chk(rdata & m, x);
      @(posedge clk);
      #1;
   endtask
   task automatic wait_tick();
      int n = 0;
      while (tick !== 1'b1 && n < 2 * TL) begin
         @(posedge clk);
         #1 n++;
      end
      if (n == 2 * TL) chk(8'h00, 8'h01);
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic cal_case();
      wait_tick();
      for (int i = 0; i < 7; i++) begin
         wr_reg(ADDR_SEC + 8'(i), t[i] | fz[i]);
      end
      next_time();
      wait_tick();
      for (int i = 0; i < 7; i++) begin
         rd_chk(ADDR_SEC + 8'(i), e[i]);
      end
   endtask
   task automatic summarize();
      $display("Mismatches %0d of %0d checks", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   int tick_gap = -1;
   always @(posedge clk) begin
      if (tick === 1'b1) begin
         if (tick_gap >= 0) chk(8'(tick_gap), 8'(TL - 1));
         tick_gap = 0;
      end else if (tick_gap >= 0) begin
         tick_gap++;
      end
   end

   initial begin
      #200000;
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      summarize();
   end

   initial begin
      void'($urandom(32'h089976eb));
      repeat (5) @(posedge clk);
      #1 rstn = 1;
      repeat (4) @(posedge clk);
      #1;
      rd_chk(ADDR_PORT, RST_PORT);
      chk({4'h0, poe}, 8'h0c);
      chk({4'h0, pout & poe}, 8'h08);
      rd_chk(ADDR_FLAGS, 8'h02, 8'h7f);
      rd_chk(ADDR_CTRL, 8'h00, 8'h7f);
      wr_reg(ADDR_FLAGS, 8'h00);
      rd_chk(ADDR_FLAGS, 8'h00, 8'h7f);
      wr_reg(ADDR_FLAGS, 8'h3e);
      rd_chk(ADDR_FLAGS, 8'h00, 8'h7f);
      wr_reg(ADDR_NV_LO, 8'ha5);
      rd_chk(ADDR_NV_LO, 8'h00);
      wr_reg(ADDR_CTRL, 8'h45);
      rd_chk(ADDR_CTRL, 8'h40, 8'h7f);
      for (int i = 0; i < NV_BYTES; i++) begin
         v = 8'($urandom());
         wr_reg(ADDR_NV_LO + 8'(i), v);
         rd_chk(ADDR_NV_LO + 8'(i), v);
      end
      for (int i = 0; i < UID_BYTES; i++) begin
         wr_reg(ADDR_UID_LO + 8'(i), ~UID[8 * i +: 8]);
         rd_chk(ADDR_UID_LO + 8'(i), UID[8 * i +: 8]);
      end
      for (int i = 8; i < 14; i++) begin
         v = 8'($urandom()) & ((i == 13) ? 8'h7f : 8'hff);
         wr_reg(8'(i), v);
         rd_chk(8'(i), v, (i == 13) ? 8'h7f : 8'hff);
      end
      rd_chk(8'h20, 8'h00);
      for (int k = 0; k < 16; k++) begin
         d = 4'($urandom());
         l = 4'($urandom());
         ext_en = 4'($urandom());
         ext_val = 4'($urandom());
         wr_reg(ADDR_PORT, {4'h0, l});
         chk({4'h0, poe}, 8'h00);
         wr_reg(ADDR_PORT, {d, l});
         for (int i = 0; i < 4; i++) begin
            v[i] = d[i] && (i > 1 || !l[i]);
            v[i + 4] = v[i] ? (i > 1 && l[i]) : (!ext_en[i] || ext_val[i]);
         end
         chk({4'h0, poe}, {4'h0, v[3:0]});
         chk({4'h0, pout & poe}, {4'h0, v[7:4] & v[3:0]});
         repeat (4) @(posedge clk);
         #1;
         rd_chk(ADDR_PORT, {d, v[7:4]});
      end
      for (int k = 0; k < 26; k++) begin
         if (k < 6) begin
            for (int i = 0; i < 7; i++) t[i] = cn[k][8 * i +: 8];
         end else begin
            t[0] = i2b($urandom_range(59));
            t[1] = i2b($urandom_range(59));
            t[2] = i2b($urandom_range(23));
            t[3] = 8'h01 << $urandom_range(6);
            t[4] = i2b($urandom_range(28, 1));
            t[5] = i2b($urandom_range(12, 1));
            t[6] = i2b($urandom_range(99));
         end
         cal_case();
      end
      summarize();
   end
endmodule
`default_nettype wire
